// ---- verilog/wdt_pkg.sv ----
// Shared constants and types for the watchdog feed timer
package wdt_pkg;

  // Structure widths
  localparam int PRESC_W  = 13;
  localparam int TAP_BASE = 5;
  localparam int TAP_W    = 3;
  localparam int TIMER_W  = 8;
  localparam int DATA_W   = 8;
  localparam int SEL_W    = 3;

  // Register select codes on the special function register port
  localparam logic [SEL_W-1:0] SEL_CTRL     = 3'h0;
  localparam logic [SEL_W-1:0] SEL_AUTOLOAD = 3'h1;
  localparam logic [SEL_W-1:0] SEL_FEED1    = 3'h2;
  localparam logic [SEL_W-1:0] SEL_FEED2    = 3'h3;

  // Feed keys
  localparam logic [DATA_W-1:0] FEED_KEY1 = 8'ha5;
  localparam logic [DATA_W-1:0] FEED_KEY2 = 8'h5a;

  // Field positions in watchdog_control
  localparam int CTRL_TAP_HI = 7;
  localparam int CTRL_TAP_MID = 6;
  localparam int CTRL_TAP_LO = 5;
  localparam int CTRL_RUN    = 2;
  localparam int CTRL_TOF    = 1;

  // Reset values, zero constants and the timer step
  localparam logic [TAP_W-1:0]   RST_TAP      = 3'h7;
  localparam logic               RST_RUN      = 1'b1;
  localparam logic [DATA_W-1:0]  RST_AUTOLOAD = 8'h00;
  localparam logic [TIMER_W-1:0] RST_TIMER    = 8'h00;
  localparam logic [DATA_W-1:0]  RDATA_ZERO   = 8'h00;
  localparam logic [TIMER_W-1:0] TIMER_ZERO   = 8'h00;
  localparam logic [TIMER_W-1:0] TIMER_STEP   = 8'h01;

  // Feed sequencer states
  typedef enum logic [1:0] {
    FEED_IDLE  = 2'b01,
    FEED_ARMED = 2'b10
  } wdt_feed_e;

endpackage

// ---- verilog/wdt_prescaler.sv ----
// Watchdog prescaler with selectable decrement tap
`timescale 1ns/10ps
module wdt_prescaler #(
  parameter int PRESC_W  = wdt_pkg::PRESC_W,
  parameter int TAP_BASE = wdt_pkg::TAP_BASE,
  parameter int TAP_W    = wdt_pkg::TAP_W
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             timer_clock,
  input  wire logic             enable,
  input  wire logic             clear,
  input  wire logic [TAP_W-1:0] tap_sel,
  output logic                  dec_tick
);

  typedef struct packed {
    logic [PRESC_W-1:0] count;
  } wdt_presc_s;

  localparam logic [PRESC_W-1:0] PRESC_ZERO = '0;
  localparam logic [PRESC_W-1:0] PRESC_ONE  = {{(PRESC_W-1){1'b0}}, 1'b1};

  wdt_presc_s         st_r;
  wdt_presc_s         st_nxt;
  logic [PRESC_W-1:0] tap_mask;
  logic               step;

  // Tick is the carry into the selected bit, so tap 0 fires every 32 timer clocks
  always_comb begin
    tap_mask = PRESC_ZERO;
    for (int i = 0; i < PRESC_W; i++) begin
      tap_mask[i] = (i < (TAP_BASE + int'(tap_sel)));
    end
  end

  assign step     = enable & timer_clock;
  assign dec_tick = step & ((st_r.count & tap_mask) == tap_mask);

  always_comb begin
    st_nxt = st_r;
    if (clear) begin
      st_nxt.count = PRESC_ZERO;
    end else if (step) begin
      st_nxt.count = st_r.count + PRESC_ONE;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.count <= PRESC_ZERO;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// ---- verilog/wdt_feed_timer.sv ----
// Watchdog feed timer: register port, feed sequencer, main timer and reset request
`timescale 1ns/10ps
// Function
// - 13-bit prescaler on the shared timer clock drives an 8-bit down-counting main timer.
// - Main timer decrements on a tap from upper 8 prescaler bits, fastest every 32.
// - Decrement at zero gives underflow and reloads from the autoload value.
// - Any autoload value including zero is legal; every autoload clears the prescaler.
// - The watchdog runs after every external reset; software must disable it explicitly.
// - Main timer cannot be written; only autoload events load it.
// - Feed is key A5 to first register then 5A to second; autoloads.
// - Correct first key followed by wrong second key causes immediate watchdog reset.
// - Any other register access between the two feed writes causes watchdog reset.
// - Run and tap writes stay pending until the next valid feed completes; a flag clear takes effect at once.
// - Tap select code k gives divisor 32 times two to the k.
// - Timeout equals oscillator period times N times divisor times autoload plus one.
// - External reset: run on, autoload zero, flag clear, prescaler clear, max tap.
// - External reset beats a coincident underflow; timeout flag stays clear.
// - Underflow autoloads, sets flag, keeps run, autoload, tap; resets the device.
// - Software may clear the timeout flag to identify watchdog resets.
// - Writing zero to control then feeding stops the watchdog.
// - Tap select bits sit at control bits 7 to 5, reset to one.
// - Run bit at control bit 2 resets to one; timeout flag at bit 1.
module wdt_feed_timer #(
  parameter int PRESC_W  = wdt_pkg::PRESC_W,
  parameter int TAP_BASE = wdt_pkg::TAP_BASE
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        timer_clock,
  input  wire logic                        sfr_wr_en,
  input  wire logic                        sfr_rd_en,
  input  wire logic [wdt_pkg::SEL_W-1:0]   sfr_sel,
  input  wire logic [wdt_pkg::DATA_W-1:0]  sfr_wdata,
  output logic      [wdt_pkg::DATA_W-1:0]  sfr_rdata,
  output logic                             wdt_reset_req,
  output logic                             run_bit,
  output logic                             timeout_flag,
  output logic                             feed_armed,
  output logic      [wdt_pkg::TIMER_W-1:0] main_timer_value
);

  typedef struct packed {
    wdt_pkg::wdt_feed_e                feed_st;
    logic                              run;
    logic [wdt_pkg::TAP_W-1:0]         tap;
    logic                              run_pend;
    logic [wdt_pkg::TAP_W-1:0]         tap_pend;
    logic                              tof;
    logic [wdt_pkg::DATA_W-1:0]        autoload;
    logic [wdt_pkg::TIMER_W-1:0]       timer;
    logic [wdt_pkg::DATA_W-1:0]        rdata;
    logic                              wdt_rst;
  } wdt_state_s;

  wdt_state_s                  st_r;
  wdt_state_s                  st_nxt;

  logic                        dec_tick;
  logic                        presc_clear;
  logic                        access;
  logic                        wr_ctrl;
  logic                        wr_autoload;
  logic                        wr_feed1;
  logic                        wr_feed2;
  logic                        key1_ok;
  logic                        key2_ok;
  logic                        feed_ok;
  logic                        violation;
  logic                        underflow;
  logic                        tof_clear;
  logic [wdt_pkg::DATA_W-1:0]  ctrl_view;

  // Register port decode; one access per cycle is assumed
  assign access      = sfr_wr_en | sfr_rd_en;
  assign wr_ctrl     = sfr_wr_en & (sfr_sel == wdt_pkg::SEL_CTRL);
  assign wr_autoload = sfr_wr_en & (sfr_sel == wdt_pkg::SEL_AUTOLOAD);
  assign wr_feed1    = sfr_wr_en & (sfr_sel == wdt_pkg::SEL_FEED1);
  assign wr_feed2    = sfr_wr_en & (sfr_sel == wdt_pkg::SEL_FEED2);
  assign key1_ok     = wr_feed1 & (sfr_wdata == wdt_pkg::FEED_KEY1);
  assign key2_ok     = wr_feed2 & (sfr_wdata == wdt_pkg::FEED_KEY2);

  // Control readback shows the settings in force, not the pending ones
  always_comb begin
    ctrl_view                        = wdt_pkg::RDATA_ZERO;
    ctrl_view[wdt_pkg::CTRL_TAP_HI]  = st_r.tap[2];
    ctrl_view[wdt_pkg::CTRL_TAP_MID] = st_r.tap[1];
    ctrl_view[wdt_pkg::CTRL_TAP_LO]  = st_r.tap[0];
    ctrl_view[wdt_pkg::CTRL_RUN]     = st_r.run;
    ctrl_view[wdt_pkg::CTRL_TOF]     = st_r.tof;
  end

  // Timer advances only when the effective run bit is set
  wdt_prescaler #(
    .PRESC_W  (PRESC_W),
    .TAP_BASE (TAP_BASE),
    .TAP_W    (wdt_pkg::TAP_W)
  ) u_presc (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .timer_clock (timer_clock),
    .enable      (st_r.run),
    .clear       (presc_clear),
    .tap_sel     (st_r.tap),
    .dec_tick    (dec_tick)
  );

  assign underflow = dec_tick & (st_r.timer == wdt_pkg::TIMER_ZERO);

  always_comb begin
    st_nxt         = st_r;
    st_nxt.wdt_rst = 1'b0;
    presc_clear    = 1'b0;
    feed_ok        = 1'b0;
    violation      = 1'b0;
    tof_clear      = 1'b0;

    // Read data is registered and held until the next read
    if (sfr_rd_en) begin
      case (sfr_sel)
        wdt_pkg::SEL_CTRL: begin
          st_nxt.rdata = ctrl_view;
        end
        wdt_pkg::SEL_AUTOLOAD: begin
          st_nxt.rdata = st_r.autoload;
        end
        default: begin
          st_nxt.rdata = wdt_pkg::RDATA_ZERO;
        end
      endcase
    end

    // Feed sequencer: the access after a good first key must be the second key
    case (st_r.feed_st)
      wdt_pkg::FEED_IDLE: begin
        if (key1_ok) begin
          st_nxt.feed_st = wdt_pkg::FEED_ARMED;
        end
      end
      wdt_pkg::FEED_ARMED: begin
        if (access) begin
          st_nxt.feed_st = wdt_pkg::FEED_IDLE;
          if (key2_ok) begin
            feed_ok = 1'b1;
          end else if (wr_feed2) begin
            violation = 1'b1;
          end else begin
            violation = 1'b1;
          end
        end
      end
      default: begin
        st_nxt.feed_st = wdt_pkg::FEED_IDLE;
      end
    endcase

    // Writes land only outside a feed; inside one they are the violation itself
    if (st_r.feed_st == wdt_pkg::FEED_IDLE) begin
      if (wr_ctrl) begin
        st_nxt.tap_pend = {sfr_wdata[wdt_pkg::CTRL_TAP_HI], sfr_wdata[wdt_pkg::CTRL_TAP_MID],
                           sfr_wdata[wdt_pkg::CTRL_TAP_LO]};
        st_nxt.run_pend = sfr_wdata[wdt_pkg::CTRL_RUN];
        tof_clear       = ~sfr_wdata[wdt_pkg::CTRL_TOF];
      end
      if (wr_autoload) begin
        st_nxt.autoload = sfr_wdata;
      end
    end

    if (tof_clear) begin
      st_nxt.tof = 1'b0;
    end

    // Main timer has no write path; it counts down or reloads
    if (dec_tick) begin
      if (underflow) begin
        st_nxt.timer = st_r.autoload;
      end else begin
        st_nxt.timer = st_r.timer - wdt_pkg::TIMER_STEP;
      end
    end

    // Valid feed commits pending control and reloads
    if (feed_ok) begin
      st_nxt.run   = st_r.run_pend;
      st_nxt.tap   = st_r.tap_pend;
      st_nxt.timer = st_r.autoload;
      presc_clear  = 1'b1;
    end

    // Watchdog reset: later than the clear so a coincident event keeps the flag
    if (underflow || violation) begin
      st_nxt.timer   = st_r.autoload;
      st_nxt.tof     = 1'b1;
      st_nxt.wdt_rst = 1'b1;
      st_nxt.feed_st = wdt_pkg::FEED_IDLE;
      presc_clear    = 1'b1;
    end
  end

  // External reset is asynchronous, so it always wins over an underflow
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.feed_st  <= wdt_pkg::FEED_IDLE;
      st_r.run      <= wdt_pkg::RST_RUN;
      st_r.tap      <= wdt_pkg::RST_TAP;
      st_r.run_pend <= wdt_pkg::RST_RUN;
      st_r.tap_pend <= wdt_pkg::RST_TAP;
      st_r.tof      <= 1'b0;
      st_r.autoload <= wdt_pkg::RST_AUTOLOAD;
      st_r.timer    <= wdt_pkg::RST_TIMER;
      st_r.rdata    <= wdt_pkg::RDATA_ZERO;
      st_r.wdt_rst  <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // All outputs straight from the state register
  assign sfr_rdata        = st_r.rdata;
  assign wdt_reset_req    = st_r.wdt_rst;
  assign run_bit          = st_r.run;
  assign timeout_flag     = st_r.tof;
  assign feed_armed       = (st_r.feed_st == wdt_pkg::FEED_ARMED);
  assign main_timer_value = st_r.timer;

endmodule

// ---- verification/wdt_feed_timer_props.sv ----
// Concurrent property checker for the watchdog feed timer
`timescale 1ns/10ps
module wdt_feed_timer_props #(
  parameter int PRESC_W  = wdt_pkg::PRESC_W,
  parameter int TAP_BASE = wdt_pkg::TAP_BASE
) (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       timer_clock,
  input wire logic       sfr_wr_en,
  input wire logic       sfr_rd_en,
  input wire logic [2:0] sfr_sel,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       wdt_reset_req,
  input wire logic       run_bit,
  input wire logic       timeout_flag,
  input wire logic       feed_armed,
  input wire logic [7:0] main_timer_value
);
  logic       good_fd;
  logic [7:0] al_r;
  // Shadow of the autoload register; writes while armed are dropped
  assign good_fd = feed_armed && sfr_wr_en && sfr_sel == wdt_pkg::SEL_FEED2 && sfr_wdata == wdt_pkg::FEED_KEY2;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) al_r <= wdt_pkg::RST_AUTOLOAD;
    else if (sfr_wr_en && !feed_armed && sfr_sel == wdt_pkg::SEL_AUTOLOAD) al_r <= sfr_wdata;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_req_one_cycle: assert property (wdt_reset_req |=> !wdt_reset_req) else $error("reset pulse too long");
  a_req_sets_flag: assert property (wdt_reset_req |-> timeout_flag && main_timer_value == $past(al_r))
    else $error("reset without flag or reload");
  a_bad_key: assert property (feed_armed && sfr_wr_en && sfr_sel == wdt_pkg::SEL_FEED2 &&
    sfr_wdata != wdt_pkg::FEED_KEY2 |=> wdt_reset_req) else $error("wrong second key not punished");
  a_other_access: assert property (feed_armed && (sfr_rd_en || sfr_wr_en && sfr_sel != wdt_pkg::SEL_FEED2)
    |=> wdt_reset_req && !feed_armed) else $error("intervening access not punished");
  a_key_arms: assert property (!feed_armed && sfr_wr_en && sfr_sel == wdt_pkg::SEL_FEED1 &&
    sfr_wdata == wdt_pkg::FEED_KEY1 |=> feed_armed || wdt_reset_req) else $error("first key not armed");
  a_feed_reload: assert property (good_fd |=> main_timer_value == $past(al_r) && !feed_armed)
    else $error("feed did not reload");
  a_stop_holds: assert property (!run_bit && !feed_armed |=> $stable(main_timer_value))
    else $error("stopped timer moved");
  a_step_by_one: assert property (!wdt_reset_req && !$past(good_fd)
    && main_timer_value != $past(main_timer_value) |-> main_timer_value == $past(main_timer_value) - 8'h01)
    else $error("timer changed wrongly");
  a_req_has_cause: assert property (wdt_reset_req
    |-> $past(feed_armed) || $past(main_timer_value) == 8'h00) else $error("reset without cause");
  a_flag_kept: assert property (timeout_flag && !(sfr_wr_en && !feed_armed && sfr_sel == wdt_pkg::SEL_CTRL &&
    !sfr_wdata[1]) |=> timeout_flag) else $error("flag lost");
  a_ctrl_read: assert property (sfr_rd_en && !feed_armed && sfr_sel == wdt_pkg::SEL_CTRL |=>
    sfr_rdata[4:0] == {2'b00, $past(run_bit), $past(timeout_flag), 1'b0}) else $error("control readback wrong");
  // Without a timer clock pulse or a pending feed nothing may touch the main timer
  a_timer_quiet: assert property (!timer_clock && !feed_armed |=> $stable(main_timer_value))
    else $error("timer moved without a tick");
  c_feed: cover property (good_fd);
  c_underflow: cover property (wdt_reset_req && !$past(feed_armed));
  c_stopped: cover property (!run_bit [*2]);
endmodule
bind wdt_feed_timer wdt_feed_timer_props #(.PRESC_W(PRESC_W), .TAP_BASE(TAP_BASE)) u_props (.mclk(mclk),
  .rst_n(rst_n), .timer_clock(timer_clock), .sfr_wr_en(sfr_wr_en), .sfr_rd_en(sfr_rd_en), .sfr_sel(sfr_sel),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .wdt_reset_req(wdt_reset_req), .run_bit(run_bit),
  .timeout_flag(timeout_flag), .feed_armed(feed_armed), .main_timer_value(main_timer_value));

// ---- verification/watchdog_feed_timer_test.sv ----
// Self-checking bench for the watchdog feed timer
`timescale 1ns/10ps
module watchdog_feed_timer_test;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       timer_clock = 1'b0;
  logic       sfr_wr_en = 1'b0;
  logic       sfr_rd_en = 1'b0;
  logic [2:0] sfr_sel = 3'h0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata, main_timer_value;
  logic       wdt_reset_req, run_bit, timeout_flag, feed_armed;
  int         n_mismatch = 0;
  int         checks_done = 0;
  int         n_rst = 0;
  int         k;
  wdt_feed_timer dut (.mclk(mclk), .rst_n(rst_n), .timer_clock(timer_clock), .sfr_wr_en(sfr_wr_en),
    .sfr_rd_en(sfr_rd_en), .sfr_sel(sfr_sel), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .wdt_reset_req(wdt_reset_req), .run_bit(run_bit), .timeout_flag(timeout_flag),
    .feed_armed(feed_armed), .main_timer_value(main_timer_value));
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk) if (wdt_reset_req === 1'b1) n_rst <= n_rst + 1;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One access then an idle cycle, so strobes never toggle twice in a step
  task automatic acc(input logic wr, input logic [2:0] sel, input logic [7:0] d);
    sfr_sel = sel;
    sfr_wdata = d;
    sfr_wr_en = wr;
    sfr_rd_en = !wr;
    @(posedge mclk);
    #1 sfr_wr_en = 1'b0;
    sfr_rd_en = 1'b0;
    @(posedge mclk);
    #1;
  endtask
  task automatic feed;
    acc(1'b1, wdt_pkg::SEL_FEED1, wdt_pkg::FEED_KEY1);
    acc(1'b1, wdt_pkg::SEL_FEED2, wdt_pkg::FEED_KEY2);
  endtask
  // Pulses on consecutive cycles, then two quiet edges for the timer to settle
  task automatic tick(input int n);
    timer_clock = 1'b1;
    repeat (n) @(posedge mclk);
    #1 timer_clock = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000;
    n_mismatch++;
    results();
  end
  initial begin
    repeat (12) @(posedge mclk);
    #1 rst_n = 1'b1;
    acc(1'b0, wdt_pkg::SEL_CTRL, 8'h00);
    chk(sfr_rdata, 8'he4);
    chk(main_timer_value, 8'h00);
    acc(1'b1, wdt_pkg::SEL_AUTOLOAD, 8'h03);
    acc(1'b0, wdt_pkg::SEL_AUTOLOAD, 8'h00);
    chk(sfr_rdata, 8'h03);
    acc(1'b1, wdt_pkg::SEL_CTRL, 8'h04);
    acc(1'b0, wdt_pkg::SEL_CTRL, 8'h00);
    chk(sfr_rdata, 8'he4);
    for (k = 0; k < 8; k++) begin
      acc(1'b1, wdt_pkg::SEL_CTRL, {k[2:0], 5'h04});
      feed();
      acc(1'b0, wdt_pkg::SEL_CTRL, 8'h00);
      chk(sfr_rdata, {k[2:0], 5'h04});
      chk(main_timer_value, 8'h03);
      tick((32 << k) - 1);
      chk(main_timer_value, 8'h03);
      tick(1);
      chk(main_timer_value, 8'h02);
    end
    acc(1'b1, wdt_pkg::SEL_CTRL, 8'h04);
    feed();
    tick(127);
    chk(main_timer_value, 8'h00);
    chk(n_rst[7:0], 8'h00);
    tick(1);
    chk(n_rst[7:0], 8'h01);
    chk(main_timer_value, 8'h03);
    acc(1'b0, wdt_pkg::SEL_CTRL, 8'h00);
    chk(sfr_rdata, 8'h06);
    acc(1'b1, wdt_pkg::SEL_CTRL, 8'h04);
    chk({7'h00, timeout_flag}, 8'h00);
    acc(1'b1, wdt_pkg::SEL_FEED1, wdt_pkg::FEED_KEY1);
    chk({7'h00, feed_armed}, 8'h01);
    acc(1'b1, wdt_pkg::SEL_FEED2, 8'h5b);
    chk(n_rst[7:0], 8'h02);
    chk({7'h00, timeout_flag}, 8'h01);
    acc(1'b1, wdt_pkg::SEL_FEED1, wdt_pkg::FEED_KEY1);
    acc(1'b0, 3'h5, 8'h00);
    chk(sfr_rdata, 8'h00);
    chk(n_rst[7:0], 8'h03);
    chk({7'h00, timeout_flag}, 8'h01);
    // Mid-run external reset must undo the watchdog's own settings and clear the flag
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    acc(1'b0, wdt_pkg::SEL_CTRL, 8'h00);
    chk(sfr_rdata, 8'he4);
    chk(main_timer_value, 8'h00);
    acc(1'b0, wdt_pkg::SEL_AUTOLOAD, 8'h00);
    chk(sfr_rdata, 8'h00);
    acc(1'b1, wdt_pkg::SEL_CTRL, 8'h00);
    feed();
    chk({7'h00, run_bit}, 8'h00);
    // Timer sits at zero, so any count that slipped through would underflow at once
    tick(300);
    chk(main_timer_value, 8'h00);
    chk(n_rst[7:0], 8'h03);
    results();
  end
endmodule
